// [hdr_regs.svh]
`ifndef HDR_REGS_SVH
`define HDR_REGS_SVH
// register indices on the plain register port
`define HDR_ADDR_CCP_MODE      4'h0
`define HDR_ADDR_CMP_LOW       4'h1
`define HDR_ADDR_CMP_HIGH      4'h2
`define HDR_ADDR_AUTOSHUT      4'h3
`define HDR_ADDR_DB_RESTART    4'h4
`define HDR_ADDR_PERIOD        4'h5
`define HDR_ADDR_INT_STATUS    4'h6
`define HDR_ADDR_INT_MASK      4'h7
// field positions
`define HDR_RESTART_EN_BIT     7
`define HDR_SHUT_FLAG_BIT      7
`define HDR_SRC_MSB            6
`define HDR_SRC_LSB            4
`define HDR_PSSA_MSB           3
`define HDR_PSSA_LSB           2
`define HDR_PSSB_MSB           1
`define HDR_PSSB_LSB           0
// reset values
`define HDR_RST_CCP_MODE       8'h00
`define HDR_RST_AUTOSHUT       8'h00
`define HDR_RST_DB_RESTART     8'h00
`define HDR_RST_PERIOD         8'hFF
// instruction cycle is four oscillator periods
`define HDR_TOSC_PER_TCY       4
`endif

// [hdr_pkg.sv]
package hdr_pkg;
   typedef enum logic [1:0] {
      HDR_RUN      = 2'b00,
      HDR_SHUT     = 2'b01,
      HDR_WAIT_PER = 2'b10
   } hdr_state_t;
   typedef enum logic [1:0] {
      HDR_PIN_LOW  = 2'b00,
      HDR_PIN_HIGH = 2'b01,
      HDR_PIN_TRI0 = 2'b10,
      HDR_PIN_TRI1 = 2'b11
   } hdr_pss_t;
endpackage : hdr_pkg

// [hdr_deadband.sv]
`timescale 1ns/1ps
// delays the rising edge of one active-high request, falling edge passes at once
module hdr_deadband #(
   parameter int CW = 7
) (
   input  wire logic          clk,      // instruction clock
   input  wire logic          rst_n,    // async reset
   input  wire logic          req,      // scheduled active level
   input  wire logic [CW-1:0] dly,      // delay count
   output logic               act       // delayed active level
);
   logic [CW-1:0] cnt_ff;

   ////////////////////////////////////////////////////////////////////////
   // count while requested; a zero count is satisfied at once
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else if (!req) begin
         cnt_ff <= '0;
      end else if (cnt_ff != dly) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // drop is combinational so turn-off is never late; rise waits for the count
   assign act = req && (cnt_ff == dly);
endmodule : hdr_deadband

// [hdr_halfbridge.sv]
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// - half-bridge mode gives programmable dead band between complementary outputs
// - only inactive-to-active edges are delayed; turn-off is immediate
// - delay is counted in instruction cycles of four oscillator periods
// - bits 6..0 of the control register hold the delay count
// - restart enable set: flag clears when shutdown ends, outputs restart
// - restart enable clear: outputs stay shut until software clears flag
// - shutdown forces pins without waiting for a clock; the flag sets once the synchronised source agrees
// - with auto restart, flag stays set while shutdown condition holds
// - software writes to the flag are ignored while shutdown persists
// - after restart, output resumes only at start of next period
module hdr_halfbridge #(
   parameter int DW = 7                      // delay count width
) (
   input  wire logic       CORE_CLK,         // instruction clock, 10 MHz
   input  wire logic       RSTN,             // async reset, active low
   input  wire logic [3:0] ADDR,             // register index
   input  wire logic [7:0] WDATA,            // write data
   input  wire logic       WR,               // write strobe
   input  wire logic       RD,               // read strobe
   output logic      [7:0] RDATA,            // read data, cycle after RD
   input  wire logic       SHDN_INT_N,       // external shutdown pin, low active
   input  wire logic       CMP1_OUT,         // comparator 1 output
   input  wire logic       CMP2_OUT,         // comparator 2 output
   output logic            PWM_OUTPUT_A,     // output pin a level
   output logic            PWM_OUTPUT_A_OE,  // output pin a enable
   output logic            PWM_OUTPUT_B,     // output pin b level
   output logic            PWM_OUTPUT_B_OE,  // output pin b enable
   output logic            IRQ               // level interrupt
);
   `include "hdr_regs.svh"

   logic [7:0]        ccp_mode_control_ff;
   logic [7:0]        cmp_low_ff;
   logic [7:0]        cmp_high_ff;
   logic [6:0]        autoshut_cfg_ff;       // source select and pin states
   logic              shutdown_status_flag_ff;
   logic [7:0]        deadband_restart_control_ff;
   logic [7:0]        period_ff;
   logic [7:0]        tmr_ff;
   logic [1:0]        int_status_ff;
   logic [1:0]        int_mask_ff;
   hdr_pkg::hdr_state_t state_ff;
   hdr_pkg::hdr_state_t nxt_state;
   logic [2:0]        src_raw;               // c1 high, c2 high, pin low; all active high
   logic [2:0]        src_lvl;               // filtered source levels
   logic              pwm_raw_ff;
   logic              out_a_ff;
   logic              out_b_ff;
   logic              oe_a_ff;
   logic              oe_b_ff;
   logic              irq_ff;
   logic [7:0]        rdata_ff;

   logic              shut_cond;
   logic              shut_src_async;
   logic              flag_wr;
   logic              period_start;
   logic              act_a;
   logic              act_b;
   logic              pwm_en;
   logic              running;
   logic              restart_evt;
   logic [2:0]        src;
   logic              force_pins;
   logic [1:0]        int_clr;
   logic [1:0]        int_set;

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers, one per shutdown source; the pin is inverted first so
   // every source is active high and every chain resets to its idle level
   assign src_raw = {!SHDN_INT_N, CMP2_OUT, CMP1_OUT};

   for (genvar i = 0; i < 3; i++) begin : g_sync
      logic [2:0] sync_ff;
      logic       lvl_ff;

      // only the second stage reads the first, so a metastable first stage stays contained
      always_ff @(posedge CORE_CLK or negedge RSTN) begin
         if (!RSTN) begin
            sync_ff <= 3'h0;
         end else begin
            sync_ff <= {sync_ff[1:0], src_raw[i]};
         end
      end

      // a change counts once stages two and three agree
      always_ff @(posedge CORE_CLK or negedge RSTN) begin
         if (!RSTN) begin
            lvl_ff <= 1'b0;
         end else if (sync_ff[1] == sync_ff[2]) begin
            lvl_ff <= sync_ff[2];
         end
      end

      assign src_lvl[i] = lvl_ff;
   end

   ////////////////////////////////////////////////////////////////////////
   // shutdown condition from selected sources
   assign src       = autoshut_cfg_ff[`HDR_SRC_MSB:`HDR_SRC_LSB];
   // select bit 0 is comparator 1, bit 1 comparator 2, bit 2 the pin held low
   assign shut_cond = |(src & src_lvl);
   // raw sources force pins with no clock; synchronised copy drives the flag
   assign shut_src_async = |(src & src_raw);
   assign flag_wr   = WR && (ADDR == `HDR_ADDR_AUTOSHUT);
   assign pwm_en    = (ccp_mode_control_ff[3:2] == 2'b11);   // pwm mode select

   ////////////////////////////////////////////////////////////////////////
   // shutdown flag: condition wins over any clear
   // firmware may also set the flag itself, which is a shutdown like any other
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         shutdown_status_flag_ff <= 1'b0;
      end else if (shut_cond) begin
         shutdown_status_flag_ff <= 1'b1;
      end else if (flag_wr) begin
         shutdown_status_flag_ff <= WDATA[`HDR_SHUT_FLAG_BIT];
      end else if (deadband_restart_control_ff[`HDR_RESTART_EN_BIT]) begin
         shutdown_status_flag_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // period timer; a period starts when the timer wraps
   // duty compares against the next count so the pin lines up with the timer
   assign period_start = (tmr_ff == period_ff);

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         tmr_ff     <= 8'h00;
         pwm_raw_ff <= 1'b0;
      end else begin
         tmr_ff     <= period_start ? 8'h00 : tmr_ff + 8'h01;
         // duty is the low compare byte; zero duty gives constant inactive
         pwm_raw_ff <= period_start ? (cmp_low_ff != 8'h00) :
                       ((tmr_ff + 8'h01) < cmp_low_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // restart sequencing: resume only on a period boundary
   // the period wait keeps a restart from emitting a runt first pulse
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         hdr_pkg::HDR_RUN: begin
            if (shutdown_status_flag_ff || shut_cond) begin
               nxt_state = hdr_pkg::HDR_SHUT;
            end
         end
         hdr_pkg::HDR_SHUT: begin
            if (!shutdown_status_flag_ff && !shut_cond) begin
               nxt_state = hdr_pkg::HDR_WAIT_PER;
            end
         end
         hdr_pkg::HDR_WAIT_PER: begin
            if (shutdown_status_flag_ff || shut_cond) begin
               nxt_state = hdr_pkg::HDR_SHUT;
            end else if (period_start) begin
               nxt_state = hdr_pkg::HDR_RUN;
            end
         end
         default: nxt_state = hdr_pkg::HDR_SHUT;
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         state_ff <= hdr_pkg::HDR_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // running also waits for the flag so a firmware shutdown takes effect at once
   assign running     = (state_ff == hdr_pkg::HDR_RUN) && !shutdown_status_flag_ff;
   assign restart_evt = (state_ff == hdr_pkg::HDR_WAIT_PER) && (nxt_state == hdr_pkg::HDR_RUN);

   ////////////////////////////////////////////////////////////////////////
   // dead band: a drives active with pwm, b with its complement
   // each side counts its own delay so both turn-on edges see the same dead band
   hdr_deadband #(.CW(DW)) u_db_a (
      .clk   (CORE_CLK),
      .rst_n (RSTN),
      .req   (running && pwm_raw_ff),
      .dly   (deadband_restart_control_ff[DW-1:0]),
      .act   (act_a)
   );
   hdr_deadband #(.CW(DW)) u_db_b (
      .clk   (CORE_CLK),
      .rst_n (RSTN),
      .req   (running && !pwm_raw_ff),
      .dly   (deadband_restart_control_ff[DW-1:0]),
      .act   (act_b)
   );

   ////////////////////////////////////////////////////////////////////////
   // output pins; polarity from mode bits 1:0, shutdown state per pin pair
   // enables follow the mode so an idle block leaves both pins released
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         out_a_ff <= 1'b0;
         out_b_ff <= 1'b0;
         oe_a_ff  <= 1'b0;
         oe_b_ff  <= 1'b0;
      end else begin
         oe_a_ff  <= pwm_en;
         oe_b_ff  <= pwm_en;
         out_a_ff <= act_a ^ ccp_mode_control_ff[1];
         out_b_ff <= act_b ^ ccp_mode_control_ff[0];
      end
   end

   // any selected raw source, a set flag or a pending restart keeps the pins parked
   assign force_pins = pwm_en && (shut_src_async || shutdown_status_flag_ff ||
                                  (state_ff != hdr_pkg::HDR_RUN));

   // pin override bypasses the flops so shutdown needs no clock edge
   always_comb begin
      PWM_OUTPUT_A    = out_a_ff;
      PWM_OUTPUT_A_OE = oe_a_ff;
      PWM_OUTPUT_B    = out_b_ff;
      PWM_OUTPUT_B_OE = oe_b_ff;
      if (force_pins) begin
         PWM_OUTPUT_A    = autoshut_cfg_ff[`HDR_PSSA_LSB];
         PWM_OUTPUT_A_OE = !autoshut_cfg_ff[`HDR_PSSA_MSB];
         PWM_OUTPUT_B    = autoshut_cfg_ff[`HDR_PSSB_LSB];
         PWM_OUTPUT_B_OE = !autoshut_cfg_ff[`HDR_PSSB_MSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register writes
   // the flag bit of the shutdown register lives in its own process above
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         ccp_mode_control_ff         <= `HDR_RST_CCP_MODE;
         cmp_low_ff                  <= 8'h00;
         cmp_high_ff                 <= 8'h00;
         autoshut_cfg_ff             <= 7'h00;
         deadband_restart_control_ff <= `HDR_RST_DB_RESTART;
         period_ff                   <= `HDR_RST_PERIOD;
         int_mask_ff                 <= 2'h0;
      end else if (WR) begin
         unique case (ADDR)
            `HDR_ADDR_CCP_MODE:   ccp_mode_control_ff <= WDATA;
            `HDR_ADDR_CMP_LOW:    cmp_low_ff <= WDATA;
            `HDR_ADDR_CMP_HIGH:   cmp_high_ff <= WDATA;
            `HDR_ADDR_AUTOSHUT:   autoshut_cfg_ff <= WDATA[6:0];
            `HDR_ADDR_DB_RESTART: deadband_restart_control_ff <= WDATA;
            `HDR_ADDR_PERIOD:     period_ff <= WDATA;
            `HDR_ADDR_INT_MASK:   int_mask_ff <= WDATA[1:0];
            default: ;
         endcase
      end
   end

   // write-one-to-clear mask and this cycle's events
   assign int_clr = (WR && ADDR == `HDR_ADDR_INT_STATUS) ? WDATA[1:0] : 2'h0;
   assign int_set = {restart_evt,
                     (state_ff == hdr_pkg::HDR_RUN) && (nxt_state == hdr_pkg::HDR_SHUT)};

   // sticky events: bit0 shutdown entry from run, bit1 restart; set wins over clear
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         int_status_ff <= 2'h0;
      end else begin
         int_status_ff <= (int_status_ff & ~int_clr) | int_set;
      end
   end

   // registered so the pin cannot glitch while status and mask settle
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= |(int_status_ff & int_mask_ff);
      end
   end
   assign IRQ = irq_ff;

   ////////////////////////////////////////////////////////////////////////
   // read data, valid one cycle after the strobe only
   // zero between reads keeps a stale value off a shared read bus
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         rdata_ff <= 8'h00;
      end else if (RD) begin
         unique case (ADDR)
            `HDR_ADDR_CCP_MODE:   rdata_ff <= ccp_mode_control_ff;
            `HDR_ADDR_CMP_LOW:    rdata_ff <= cmp_low_ff;
            `HDR_ADDR_CMP_HIGH:   rdata_ff <= cmp_high_ff;
            `HDR_ADDR_AUTOSHUT:   rdata_ff <= {shutdown_status_flag_ff, autoshut_cfg_ff};
            `HDR_ADDR_DB_RESTART: rdata_ff <= deadband_restart_control_ff;
            `HDR_ADDR_PERIOD:     rdata_ff <= period_ff;
            `HDR_ADDR_INT_STATUS: rdata_ff <= {6'h00, int_status_ff};
            `HDR_ADDR_INT_MASK:   rdata_ff <= {6'h00, int_mask_ff};
            default:              rdata_ff <= 8'h00;   // unmapped reads zero
         endcase
      end else begin
         rdata_ff <= 8'h00;
      end
   end
   assign RDATA = rdata_ff;
endmodule : hdr_halfbridge

// [hdr_switch_model.sv]
`timescale 1ns/1ps
// upper and lower switch drivers; a released pin is pulled low on the board
module hdr_switch_model (
   input  wire logic clk,       // instruction clock
   input  wire logic hi_in,     // pin a level
   input  wire logic hi_oe,     // pin a enable
   input  wire logic lo_in,     // pin b level
   input  wire logic lo_oe,     // pin b enable
   output logic      hi_on,     // upper switch on
   output logic      lo_on,     // lower switch on
   output int        shoot_cnt  // cycles with both on
);
   ////////////////////////////////////////
   // undriven pins read as the pull-down level, never the last value
   assign hi_on = hi_oe & hi_in;
   assign lo_on = lo_oe & lo_in;
   int shoot_q = 0;
   // both switches on shorts the supply
   always @(negedge clk) if (hi_on && lo_on) shoot_q++;
   assign shoot_cnt = shoot_q;
endmodule : hdr_switch_model

// [hdr_halfbridge_chk.sv]
`timescale 1ns/1ps
// port-level checker; shadows control bytes from the register port
module hdr_halfbridge_chk #(
   parameter int DW = 7  // delay count width
) (
   input wire logic       CORE_CLK,        // clock
   input wire logic       RSTN,            // reset, active low
   input wire logic [3:0] ADDR,            // index
   input wire logic [7:0] WDATA,           // write data
   input wire logic       WR,              // write strobe
   input wire logic       RD,              // read strobe
   input wire logic [7:0] RDATA,           // read data
   input wire logic       SHDN_INT_N,      // shutdown pin
   input wire logic       CMP1_OUT,        // comparator 1
   input wire logic       CMP2_OUT,        // comparator 2
   input wire logic       PWM_OUTPUT_A,    // pin a
   input wire logic       PWM_OUTPUT_A_OE, // pin a enable
   input wire logic       PWM_OUTPUT_B,    // pin b
   input wire logic       PWM_OUTPUT_B_OE, // pin b enable
   input wire logic       IRQ              // interrupt
);
   logic [7:0] mode_ff, ctl_ff, db_ff, msk_ff;
   logic       rd3_ff, seen_ff;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RSTN);
   ////////////////////////////////////////
   // shadows follow writes; seen_ff is conservative, any write to the flag drops it
   always_ff @(posedge CORE_CLK or negedge RSTN) begin
      if (!RSTN) begin
         {mode_ff, ctl_ff, db_ff, msk_ff} <= 32'h0000_0000;
         {rd3_ff, seen_ff} <= 2'b00;
      end else begin
         if (WR && ADDR == 4'h0) mode_ff <= WDATA;
         if (WR && ADDR == 4'h3) ctl_ff <= WDATA;
         if (WR && ADDR == 4'h4) db_ff <= WDATA;
         if (WR && ADDR == 4'h7) msk_ff <= WDATA;
         rd3_ff <= RD && ADDR == 4'h3;
         if ((WR && ADDR == 4'h3) || db_ff[7]) seen_ff <= 1'b0;
         else if (rd3_ff && RDATA[7]) seen_ff <= 1'b1;
      end
   end
   ////////////////////////////////////////
   sequence s_int_held; (!SHDN_INT_N && ctl_ff[6])[*6]; endsequence
   sequence s_rd_flag; RD && ADDR == 4'h3; endsequence
   sequence s_quiet; (db_ff[7] && SHDN_INT_N && !CMP1_OUT && !CMP2_OUT && !WR)[*8]; endsequence
   property p_flag_held; s_int_held ##0 s_rd_flag |=> RDATA[7]; endproperty
   a_flag_held: assert property (p_flag_held) else $error("flag dropped in shutdown");
   property p_auto_clear; s_quiet ##0 s_rd_flag |=> !RDATA[7]; endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("flag not auto cleared");
   property p_hold_flag; s_rd_flag ##0 (seen_ff && !db_ff[7]) |=> RDATA[7]; endproperty
   a_hold_flag: assert property (p_hold_flag) else $error("flag cleared by itself");
   property p_force_a;
      (mode_ff[3:2] == 2'b11 && ctl_ff[6] && ctl_ff[3:2] == 2'b01 && !SHDN_INT_N)
      |-> (PWM_OUTPUT_A && PWM_OUTPUT_A_OE);
   endproperty
   a_force_a: assert property (p_force_a) else $error("pin a not forced");
   property p_force_b;
      (mode_ff[3:2] == 2'b11 && ctl_ff[6] && ctl_ff[1:0] == 2'b00 && !SHDN_INT_N)
      |-> (!PWM_OUTPUT_B && PWM_OUTPUT_B_OE);
   endproperty
   a_force_b: assert property (p_force_b) else $error("pin b not forced");
   property p_no_overlap;
      (mode_ff == 8'h0C && SHDN_INT_N && PWM_OUTPUT_A_OE && PWM_OUTPUT_B_OE)
      |-> !(PWM_OUTPUT_A && PWM_OUTPUT_B);
   endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("both pins active");
   property p_rd_idle; !RD |=> RDATA == 8'h00; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   property p_rd_db; RD && ADDR == 4'h4 |=> RDATA == db_ff; endproperty
   a_rd_db: assert property (p_rd_db) else $error("delay register mismatch");
   property p_irq_mask; (msk_ff == 8'h00)[*2] |-> !IRQ; endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");
endmodule : hdr_halfbridge_chk
bind hdr_halfbridge hdr_halfbridge_chk #(.DW(DW)) u_chk (
   .CORE_CLK(CORE_CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
   .RDATA(RDATA), .SHDN_INT_N(SHDN_INT_N), .CMP1_OUT(CMP1_OUT), .CMP2_OUT(CMP2_OUT),
   .PWM_OUTPUT_A(PWM_OUTPUT_A), .PWM_OUTPUT_A_OE(PWM_OUTPUT_A_OE),
   .PWM_OUTPUT_B(PWM_OUTPUT_B), .PWM_OUTPUT_B_OE(PWM_OUTPUT_B_OE), .IRQ(IRQ));

// [hdr_halfbridge_test.sv]
`timescale 1ns/1ps
module hdr_halfbridge_test;
   logic       core_clk, rstn, wr, rd, shdn_n, cmp1, cmp2;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, v;
   logic       pa, pa_oe, pb, pb_oe, irq, hi_on, lo_on;
   int         shoot_cnt, n_errors, comparisons;
   hdr_halfbridge dut_u (.CORE_CLK(core_clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .SHDN_INT_N(shdn_n), .CMP1_OUT(cmp1),
      .CMP2_OUT(cmp2), .PWM_OUTPUT_A(pa), .PWM_OUTPUT_A_OE(pa_oe), .PWM_OUTPUT_B(pb),
      .PWM_OUTPUT_B_OE(pb_oe), .IRQ(irq));
   hdr_switch_model sw_u (.clk(core_clk), .hi_in(pa), .hi_oe(pa_oe), .lo_in(pb),
      .lo_oe(pb_oe), .hi_on(hi_on), .lo_on(lo_on), .shoot_cnt(shoot_cnt));
   always #50 core_clk = ~core_clk;
   ////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wrap_up;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : wrap_up
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge core_clk);
      wr <= 1'b0;
   endtask : wr_reg
   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, input string what);
      @(posedge core_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge core_clk);
      rd <= 1'b0;
      @(negedge core_clk);
      check(what, rdata, e);
   endtask : rd_reg
   // counts cycles until a switch reaches a level; a hang ends the run
   task automatic wait_pin(input logic want, input logic low_side, output int n);
      n = 0;
      while (((low_side ? lo_on : hi_on) !== want) && n < 300) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 300) begin
         n_errors++;
         wrap_up();
      end
   endtask : wait_pin
   ////////////////////////////////////////
   task automatic reset_values;
      check("irq at reset", {7'h0, irq}, 8'h00);
      rd_reg(4'h0, 8'h00, "mode reset");
      rd_reg(4'h3, 8'h00, "autoshut reset");
      rd_reg(4'h4, 8'h00, "deadband reset");
      rd_reg(4'h5, 8'hFF, "period reset");
      wr_reg(4'hF, 8'h5A);
      rd_reg(4'hF, 8'h00, "unmapped");
      wr_reg(4'h4, 8'h7F);
      rd_reg(4'h4, 8'h7F, "deadband full count");
   endtask : reset_values
   // turn-off passes at once, turn-on of the other switch waits n cycles
   task automatic deadband_case(input logic [6:0] n);
      int g, w;
      wr_reg(4'h4, {1'b0, n});
      repeat (90) @(negedge core_clk);
      wait_pin(1'b0, 1'b0, g);
      wait_pin(1'b1, 1'b0, g);
      wait_pin(1'b0, 1'b0, w);
      wait_pin(1'b1, 1'b1, g);
      check("gap a to b", 8'(g), 8'(n));
      wait_pin(1'b0, 1'b1, g);
      wait_pin(1'b1, 1'b0, g);
      check("gap b to a", 8'(g), 8'(n));
      // duty byte is 20, so a delayed rise with an undelayed fall leaves 20 - n
      check("on width a", 8'(w), 8'(20 - n));
   endtask : deadband_case
   task automatic shutdown_firmware;
      int g;
      wr_reg(4'h4, 8'h03);
      wr_reg(4'h7, 8'h01);
      @(posedge core_clk);
      shdn_n <= 1'b0;
      #1;
      check("forced pins", {4'h0, pa, pa_oe, pb, pb_oe}, 8'h0D);
      repeat (6) @(posedge core_clk);
      rd_reg(4'h3, 8'hC4, "flag set");
      check("irq", {7'h0, irq}, 8'h01);
      wr_reg(4'h3, 8'h44);
      rd_reg(4'h3, 8'hC4, "flag write ignored");
      @(posedge core_clk);
      shdn_n <= 1'b1;
      repeat (10) @(posedge core_clk);
      rd_reg(4'h3, 8'hC4, "flag latched");
      check("still forced", {4'h0, pa, pa_oe, pb, pb_oe}, 8'h0D);
      wr_reg(4'h3, 8'h44);
      rd_reg(4'h3, 8'h44, "flag cleared");
      wait_pin(1'b1, 1'b1, g);
      wr_reg(4'h6, 8'h03);
      repeat (2) @(negedge core_clk);
      check("irq cleared", {7'h0, irq}, 8'h00);
   endtask : shutdown_firmware
   task automatic shutdown_auto;
      int g;
      wr_reg(4'h7, 8'h00);
      wr_reg(4'h4, 8'h83);
      @(posedge core_clk);
      shdn_n <= 1'b0;
      repeat (12) @(posedge core_clk);
      rd_reg(4'h3, 8'hC4, "flag held");
      check("irq masked", {7'h0, irq}, 8'h00);
      @(posedge core_clk);
      shdn_n <= 1'b1;
      repeat (8) @(posedge core_clk);
      rd_reg(4'h3, 8'h44, "flag auto clear");
      wait_pin(1'b1, 1'b1, g);
      rd_reg(4'h6, 8'h03, "status events");
   endtask : shutdown_auto
   // comparator 2 forces the pins and sets the flag, comparator 1 holds it like the pin does
   task automatic shutdown_cmp;
      wr_reg(4'h3, 8'h34);
      @(posedge core_clk);
      cmp2 <= 1'b1;
      #1;
      check("cmp forced pins", {4'h0, pa, pa_oe, pb, pb_oe}, 8'h0D);
      repeat (6) @(posedge core_clk);
      rd_reg(4'h3, 8'hB4, "cmp flag set");
      @(posedge core_clk);
      cmp2 <= 1'b0;
      cmp1 <= 1'b1;
      repeat (6) @(posedge core_clk);
      rd_reg(4'h3, 8'hB4, "cmp flag held");
      @(posedge core_clk);
      cmp1 <= 1'b0;
      repeat (8) @(posedge core_clk);
      rd_reg(4'h3, 8'h34, "cmp flag auto clear");
      wr_reg(4'h3, 8'h44);
   endtask : shutdown_cmp
   ////////////////////////////////////////
   initial begin
      {core_clk, rstn, wr, rd, addr, wdata, cmp1, cmp2} = '0;
      shdn_n = 1'b1;
      {n_errors, comparisons} = '0;
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      reset_values();
      wr_reg(4'h5, 8'd39);
      wr_reg(4'h1, 8'd20);
      wr_reg(4'h3, 8'h44);
      wr_reg(4'h0, 8'h0C);
      repeat (300) @(posedge core_clk);
      deadband_case(7'd0);
      deadband_case(7'd3);
      deadband_case(7'd9);
      shutdown_firmware();
      shutdown_auto();
      shutdown_cmp();
      check("shoot through", {7'h0, shoot_cnt != 0}, 8'h00);
      wrap_up();
   end
endmodule : hdr_halfbridge_test
